// file: pwr_sync_pkg.sv
package pwr_sync_pkg;
  // Register offsets on the two-wire bus
  localparam logic [7:0] REG_PHASE = 8'h05;
  localparam logic [7:0] REG_COAST = 8'h12;
  localparam logic [7:0] REG_ACTIVITY = 8'h15;
  localparam logic [7:0] REG_HS_WIDTH = 8'h23;
  localparam logic [7:0] REG_SYNC_OUT = 8'h24;
  localparam logic [7:0] REG_POWER = 8'h26;
  localparam logic [7:0] REG_AUTO_PD = 8'h27;
  // Values after reset
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_COAST = 8'h00;
  localparam logic [7:0] RST_HS_WIDTH = 8'h20;
  localparam logic [7:0] RST_SYNC_OUT = 8'h80;
  localparam logic [7:0] RST_POWER = 8'h01;
  localparam logic [7:0] RST_AUTO_PD = 8'h00;
  // Field positions
  localparam int PWR_ON_BIT = 0;
  localparam int PWR_OPT_LO = 1;
  localparam int PWR_PIN_POL = 3;
  localparam int PWR_HIZ_I2S = 4;
  localparam int PWR_HIZ_SPDIF = 5;
  localparam int PWR_HIZ_SOG = 6;
  localparam int PWR_HIZ_DATA = 7;
  localparam int AUTO_EN_BIT = 7;
  localparam int HS_POL_BIT = 7;
  localparam int COAST_POL_BIT = 0;
  localparam int COAST_INT_BIT = 1;
  localparam int COAST_VS_BIT = 2;
  localparam int ACT_LO = 2;
  // Bus slave address, arbitrary value
  localparam logic [6:0] DEV_ADDR = 7'h4C;
  // Pipeline and counters
  localparam int PIPE_DEPTH = 23;
  localparam logic [4:0] FILL_DONE = 5'h17;
  localparam logic [9:0] POL_MID = 10'h200;
  localparam logic [9:0] POL_MAX = 10'h3FF;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    PS_FULL = 4'h1,
    PS_SEEK = 4'h2,
    PS_AUTO_PD = 4'h4,
    PS_POWER_DOWN = 4'h8
  } pwr_state_e;

  typedef enum logic [8:0] {
    I_IDLE = 9'h001,
    I_DEV = 9'h002,
    I_ADEV = 9'h004,
    I_SUB = 9'h008,
    I_ASUB = 9'h010,
    I_WR = 9'h020,
    I_AWR = 9'h040,
    I_RD = 9'h080,
    I_RACK = 9'h100
  } i2c_state_e;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pixel_s;

  typedef struct packed {
    pixel_s pix;
    logic hs;
  } pipe_s;

  typedef struct packed {
    logic data;
    logic sync_on_green;
    logic spdif;
    logic i2s;
  } hiz_s;
endpackage : pwr_sync_pkg

// file: power_sync_ctrl.sv
module power_sync_ctrl
  import pwr_sync_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Two-wire serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Asynchronous pins
  input wire logic pd_pin,
  input wire logic coast_pin,
  input wire logic vsync_in,
  input wire logic hsync_in,
  // Activity detect flags, same clock
  input wire logic [5:0] activity_flags,
  // Pixel data from the converters
  input wire pixel_s pixel_in,
  // Display side
  output pixel_s pixel_out,
  output logic output_data_clock,
  output logic data_valid,
  output logic hsync_output,
  // PLL and power control
  output logic pll_ref,
  output logic [4:0] phase_step,
  output pwr_state_e power_state,
  output logic core_power_on,
  output logic [1:0] pin_pd_option,
  output hiz_s hiz
);

  // Two flops in a row agreeing counts as a change
  function automatic logic [5:0] agree(input logic [5:0] a,
                                       input logic [5:0] b,
                                       input logic [5:0] held);
    agree = (a & b) | (held & (a ^ b));
  endfunction : agree

  logic [7:0] phase_q, coast_q, hsw_q, syncout_q, power_q, auto_q;
  logic [5:0] s1_q, s2_q, s3_q, f_q;
  logic [5:0] f_d;

  // Three-flop synchronisers for scl, sda, pd, coast, vsync, hsync
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 6'h03;
      s2_q <= 6'h03;
      s3_q <= 6'h03;
      f_q <= 6'h03;
    end else if (clk_en) begin
      s1_q <= {hsync_in, vsync_in, coast_pin, pd_pin, sda_in, scl_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
    end
  end

  // Filtered levels and bus events
  assign f_d = agree(s2_q, s3_q, f_q);
  wire scl_rise = f_d[0] & ~f_q[0];
  wire scl_fall = ~f_d[0] & f_q[0];
  wire bus_start = f_q[0] & f_d[0] & f_q[1] & ~f_d[1];
  wire bus_stop = f_q[0] & f_d[0] & ~f_q[1] & f_d[1];
  wire sda_v = f_q[1];

  // Register read mux
  function automatic logic [7:0] rd_reg(input logic [7:0] a,
                                        input logic [7:0] ph,
                                        input logic [7:0] co,
                                        input logic [7:0] hw,
                                        input logic [7:0] so,
                                        input logic [7:0] pw,
                                        input logic [7:0] au,
                                        input logic [5:0] act);
    if (a == REG_PHASE) rd_reg = ph;
    else if (a == REG_COAST) rd_reg = co;
    else if (a == REG_ACTIVITY) rd_reg = {act, 2'h0};
    else if (a == REG_HS_WIDTH) rd_reg = hw;
    else if (a == REG_SYNC_OUT) rd_reg = so;
    else if (a == REG_POWER) rd_reg = pw;
    else if (a == REG_AUTO_PD) rd_reg = au;
    else rd_reg = 8'h00;
  endfunction : rd_reg

  i2c_state_e ist_q;
  logic [3:0] bitc_q;
  logic [7:0] sh_q, ptr_q;
  logic rw_q, mack_q;

  wire [7:0] ptr_nx = ptr_q + 8'h01;
  wire [7:0] rd_now = rd_reg(ptr_q, phase_q, coast_q, hsw_q, syncout_q,
                             power_q, auto_q, activity_flags);
  wire [7:0] rd_next = rd_reg(ptr_nx, phase_q, coast_q, hsw_q, syncout_q,
                              power_q, auto_q, activity_flags);
  wire shifting = (ist_q == I_DEV) | (ist_q == I_SUB) | (ist_q == I_WR);
  wire byte_done = bitc_q == BYTE_BITS;
  wire wr_now = scl_fall & ~bus_start & ~bus_stop & (ist_q == I_WR)
                & byte_done;

  // Bus slave: address, sub-address, data with auto-increment
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ist_q <= I_IDLE;
      bitc_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (clk_en) begin
      if (bus_start) begin
        ist_q <= I_DEV;
        bitc_q <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        ist_q <= I_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (ist_q == I_RACK) mack_q <= ~sda_v;
        else if (shifting) begin
          sh_q <= {sh_q[6:0], sda_v};
          bitc_q <= bitc_q + 4'h1;
        end
      end else if (scl_fall) begin
        case (ist_q)
          I_DEV: if (byte_done) begin
            bitc_q <= 4'h0;
            if (sh_q[7:1] == DEV_ADDR) begin
              ist_q <= I_ADEV;
              rw_q <= sh_q[0];
              sda_oe <= 1'b1;
            end else ist_q <= I_IDLE;
          end
          I_ADEV: if (rw_q) begin
            ist_q <= I_RD;
            sh_q <= rd_now;
            sda_oe <= ~rd_now[7];
            bitc_q <= 4'h1;
          end else begin
            ist_q <= I_SUB;
            sda_oe <= 1'b0;
          end
          I_SUB: if (byte_done) begin
            ptr_q <= sh_q;
            ist_q <= I_ASUB;
            sda_oe <= 1'b1;
            bitc_q <= 4'h0;
          end
          I_WR: if (byte_done) begin
            ist_q <= I_AWR;
            sda_oe <= 1'b1;
            bitc_q <= 4'h0;
          end
          I_ASUB: begin
            ist_q <= I_WR;
            sda_oe <= 1'b0;
          end
          I_AWR: begin
            ist_q <= I_WR;
            sda_oe <= 1'b0;
            ptr_q <= ptr_nx;
          end
          I_RD: if (byte_done) begin
            ist_q <= I_RACK;
            sda_oe <= 1'b0;
            bitc_q <= 4'h0;
          end else begin
            sh_q <= {sh_q[6:0], 1'b0};
            sda_oe <= ~sh_q[6];
            bitc_q <= bitc_q + 4'h1;
          end
          I_RACK: if (mack_q) begin
            ist_q <= I_RD;
            ptr_q <= ptr_nx;
            sh_q <= rd_next;
            sda_oe <= ~rd_next[7];
            bitc_q <= 4'h1;
          end else ist_q <= I_IDLE;
          default: ist_q <= I_IDLE;
        endcase
      end
    end
  end

  // Write strobes, one per writable register
  wire wr_phase = wr_now && (ptr_q == REG_PHASE);
  wire wr_coast = wr_now && (ptr_q == REG_COAST);
  wire wr_hsw = wr_now && (ptr_q == REG_HS_WIDTH);
  wire wr_so = wr_now && (ptr_q == REG_SYNC_OUT);
  wire wr_pw = wr_now && (ptr_q == REG_POWER);
  wire wr_au = wr_now && (ptr_q == REG_AUTO_PD);

  // Control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= RST_PHASE;
      coast_q <= RST_COAST;
      hsw_q <= RST_HS_WIDTH;
      syncout_q <= RST_SYNC_OUT;
      power_q <= RST_POWER;
      auto_q <= RST_AUTO_PD;
    end else if (clk_en) begin
      if (wr_phase) phase_q <= sh_q;
      if (wr_coast) coast_q <= sh_q;
      if (wr_hsw) hsw_q <= sh_q;
      if (wr_so) syncout_q <= sh_q;
      if (wr_pw) power_q <= sh_q;
      if (wr_au) auto_q <= sh_q;
    end
  end

  // Power state decision; requests outrank activity
  wire pin_on = f_q[2] == power_q[PWR_PIN_POL];
  wire sw_pd = ~power_q[PWR_ON_BIT];
  wire pin_pd = pin_on & power_q[PWR_ON_BIT];
  wire pin_tri = pin_on & ~power_q[PWR_ON_BIT];
  wire sync_det = |({activity_flags, 2'h0} >> ACT_LO);
  wire auto_en = auto_q[AUTO_EN_BIT];
  pwr_state_e ps_d;
  assign ps_d = (sw_pd | pin_pd) ? PS_POWER_DOWN
              : sync_det ? PS_FULL
              : auto_en ? PS_AUTO_PD : PS_SEEK;

  // Power outputs; auto power-down keeps only bus, detect, sog, bandgap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_state <= PS_SEEK;
      core_power_on <= 1'b1;
      pin_pd_option <= 2'h0;
      hiz <= '0;
    end else if (clk_en) begin
      power_state <= ps_d;
      core_power_on <= (ps_d == PS_FULL) | (ps_d == PS_SEEK);
      pin_pd_option <= pin_on ? power_q[PWR_OPT_LO +: 2] : 2'h0;
      hiz.data <= power_q[PWR_HIZ_DATA] | pin_tri;
      hiz.sync_on_green <= power_q[PWR_HIZ_SOG];
      hiz.spdif <= power_q[PWR_HIZ_SPDIF] | pin_tri;
      hiz.i2s <= power_q[PWR_HIZ_I2S] | pin_tri;
    end
  end

  // Hsync polarity: the rarer level is the active one
  logic [9:0] pol_q;
  wire hs_raw = f_q[5];
  wire hs_high_act = pol_q < POL_MID;
  wire hs_act = hs_high_act ? hs_raw : ~hs_raw;
  wire [9:0] pol_d = hs_raw ? ((pol_q == POL_MAX) ? pol_q : pol_q + 10'h001)
                            : ((pol_q == 10'h000) ? pol_q : pol_q - 10'h001);

  // Coast source and level; sync bit polarity one means active high
  wire coast_ext = f_q[3] == coast_q[COAST_POL_BIT];
  wire vs_on = f_q[4];
  wire coast_on = coast_q[COAST_INT_BIT] ? vs_on
                : coast_q[COAST_VS_BIT] ? vs_on : coast_ext;

  // Polarity tracker, PLL reference gate and phase step
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pol_q <= POL_MID;
      pll_ref <= 1'b0;
      phase_step <= 5'h00;
    end else if (clk_en) begin
      pol_q <= pol_d;
      pll_ref <= hs_act & ~coast_on;
      phase_step <= phase_q[4:0];
    end
  end

  // Pixel pipeline; data moves on the half-rate tick
  pipe_s pipe_q [PIPE_DEPTH];
  logic [4:0] fill_q;
  logic [7:0] hcnt_q;
  logic last_hs_q;
  wire tick = output_data_clock;
  wire hs_edge = pipe_q[PIPE_DEPTH-1].hs & ~last_hs_q;
  wire [7:0] hcnt_d = hs_edge ? hsw_q
                    : (hcnt_q == 8'h00) ? 8'h00 : hcnt_q - 8'h01;
  wire hs_out_d = (hcnt_d != 8'h00) ~^ syncout_q[HS_POL_BIT];

  // Delay line, one entry per data set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PIPE_DEPTH; i++) pipe_q[i] <= '0;
    end else if (clk_en && tick) begin
      pipe_q[0] <= '{pix: pixel_in, hs: hs_act};
      for (int i = 1; i < PIPE_DEPTH; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end

  // Data, clock and hsync leave together, so they stay aligned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      output_data_clock <= 1'b0;
      pixel_out <= '0;
      data_valid <= 1'b0;
      fill_q <= 5'h00;
      hcnt_q <= 8'h00;
      last_hs_q <= 1'b0;
      hsync_output <= 1'b0;
      sda_out <= 1'b0;
    end else if (clk_en) begin
      output_data_clock <= ~output_data_clock;
      if (tick) begin
        pixel_out <= pipe_q[PIPE_DEPTH-1].pix;
        if (fill_q != FILL_DONE) fill_q <= fill_q + 5'h01;
        data_valid <= fill_q == FILL_DONE;
        last_hs_q <= pipe_q[PIPE_DEPTH-1].hs;
        hcnt_q <= hcnt_d;
        hsync_output <= hs_out_d;
      end
    end
  end

endmodule : power_sync_ctrl

// file: power_sync_ctrl_asserts.sv
module power_sync_ctrl_asserts
  import pwr_sync_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic reset_n,
  // Watched pins
  input logic scl_in,
  input logic coast_pin,
  input pixel_s pixel_out,
  input logic output_data_clock,
  input logic data_valid,
  input logic hsync_output,
  input logic pll_ref,
  input logic [4:0] phase_step,
  input pwr_state_e power_state,
  input logic core_power_on
);
  logic [5:0] age_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Cycles since reset, saturating; the pipeline cannot fill sooner
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      age_q <= 6'h00;
    else if (age_q != 6'h3F)
      age_q <= age_q + 6'h01;
  end

  // Bench keeps clk_en high, so the data clock must toggle every cycle
  one_state_a: assert property ($onehot(power_state))
    else $error("power state not one-hot");
  down_core_off_a: assert property (
    (power_state == PS_POWER_DOWN)[*2] |-> !core_power_on)
    else $error("core powered in power-down");
  clock_toggle_a: assert property (
    age_q != 6'h00 |=> output_data_clock != $past(output_data_clock))
    else $error("data clock missed a toggle");
  pixel_hold_a: assert property (
    $changed(pixel_out) |=> $stable(pixel_out))
    else $error("pixel held under two cycles");
  hsync_hold_a: assert property (
    $changed(hsync_output) |=> $stable(hsync_output))
    else $error("hsync output off the data set grid");
  coast_gate_a: assert property (
    (!coast_pin)[*8] |-> !pll_ref)
    else $error("reference passed during coast");
  valid_sticky_a: assert property (data_valid |=> data_valid)
    else $error("data valid dropped");
  valid_late_a: assert property (
    $rose(data_valid) |-> age_q >= 6'h2C)
    else $error("data valid before pipeline flush");
  phase_quiet_a: assert property (
    scl_in[*8] |-> $stable(phase_step))
    else $error("phase changed without bus activity");

  // Main scenarios reached
  cover property (power_state == PS_AUTO_PD);
  cover property ($rose(data_valid));
  cover property ($fell(hsync_output));
endmodule : power_sync_ctrl_asserts

// file: display_sink.sv
module display_sink
  import pwr_sync_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic reset_n,
  // Display inputs
  input pixel_s pixel_out,
  input logic output_data_clock,
  input logic data_valid,
  input logic hsync_output,
  // Observations
  output pixel_s last_pix,
  output logic [7:0] hs_width
);
  pixel_s seen_q[$];
  logic [7:0] run_q;

  // Latch mid-data on the rising data clock; flush sets are dropped
  always @(posedge output_data_clock) begin
    if (data_valid) begin
      seen_q.push_back(pixel_out);
      if (seen_q.size() > 4)
        seen_q.pop_front();
      last_pix <= pixel_out;
    end
  end

  // Width of the last active-high sync pulse, in clk cycles
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 8'h00;
      hs_width <= 8'h00;
    end else if (hsync_output) begin
      run_q <= run_q + 8'h01;
    end else if (run_q != 8'h00) begin
      hs_width <= run_q;
      run_q <= 8'h00;
    end
  end
endmodule : display_sink

// file: power_sync_ctrl_tb.sv
module power_sync_ctrl_tb
  import pwr_sync_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n, scl_in, sda_m, sda_in, sda_out, sda_oe, pd_pin, coast_pin;
  logic hsync_in, vsync_in, output_data_clock, data_valid, hsync_output;
  logic pll_ref;
  logic core_power_on;
  logic [5:0] activity_flags;
  logic [4:0] phase_step;
  logic [1:0] pin_pd_option;
  logic [7:0] hs_width, rq;
  pixel_s pixel_in, pixel_out, last_pix, pq;
  pwr_state_e power_state;
  hiz_s hiz;
  int seed = 32'hA500F4D0;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n, hi;

  // Open-drain data line: low if either side pulls
  assign sda_in = sda_m & ~(sda_oe & ~sda_out);
  always #12.5 clk = ~clk;

  power_sync_ctrl i_dut (.clk, .reset_n, .clk_en(1'b1), .scl_in, .sda_in,
    .sda_out, .sda_oe, .pd_pin, .coast_pin, .vsync_in, .hsync_in,
    .activity_flags, .pixel_in, .pixel_out, .output_data_clock, .data_valid,
    .hsync_output, .pll_ref, .phase_step, .power_state, .core_power_on,
    .pin_pd_option, .hiz);
  display_sink i_sink (.clk, .reset_n, .pixel_out, .output_data_clock,
    .data_valid, .hsync_output, .last_pix, .hs_width);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Hang guard, well beyond the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end

  // Reference pipeline: a set taken on a tick leaves 23 ticks later,
  // and the valid flag rises with the 24th set
  pixel_s model_q[$];
  always @(posedge clk) begin
    if (reset_n && output_data_clock) begin
      model_q.push_back(pixel_in);
      @(negedge clk);
      chk(data_valid, model_q.size() > PIPE_DEPTH);
      if (model_q.size() > PIPE_DEPTH)
        chk(pixel_out, model_q.pop_front());
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // One bus bit; slow enough for the input filter on both phases
  task automatic bitx(input logic b, output logic r);
    tick(2);
    sda_m <= b;
    tick(5);
    scl_in <= 1'b1;
    tick(5);
    r = sda_in;
    scl_in <= 1'b0;
  endtask : bitx

  task automatic byte_x(input logic [7:0] d, input logic mack,
                        output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(mack, a);
  endtask : byte_x

  // Start or repeated start, then stop
  task automatic start_c();
    tick(2);
    sda_m <= 1'b1;
    tick(5);
    scl_in <= 1'b1;
    tick(5);
    sda_m <= 1'b0;
    tick(5);
    scl_in <= 1'b0;
  endtask : start_c

  task automatic stop_c();
    tick(2);
    sda_m <= 1'b0;
    tick(5);
    scl_in <= 1'b1;
    tick(5);
    sda_m <= 1'b1;
    tick(5);
  endtask : stop_c

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start_c();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, q);
    byte_x(a, 1'b1, q);
    byte_x(d, 1'b1, q);
    stop_c();
  endtask : wr

  // Single-byte read; the master nack ends it
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    start_c();
    byte_x({DEV_ADDR, 1'b0}, 1'b1, q);
    byte_x(a, 1'b1, q);
    start_c();
    byte_x({DEV_ADDR, 1'b1}, 1'b1, q);
    byte_x(8'hFF, 1'b1, q);
    stop_c();
  endtask : rd

  task automatic pwr_chk(input pwr_state_e st, input logic core);
    tick(12);
    @(negedge clk);
    chk(power_state, st);
    chk(core_power_on, core);
    @(posedge clk);
  endtask : pwr_chk

  // Short active-high sync pulses, one line per 64 clocks
  task automatic pulses(input int k, output int h);
    h = 0;
    for (int i = 0; i < k * 64; i++) begin
      hsync_in <= (i % 64) < 4;
      @(posedge clk);
      h += int'(pll_ref);
    end
  endtask : pulses

  // Main sequence
  initial begin
    reset_n = 1'b0;
    scl_in = 1'b1;
    sda_m = 1'b1;
    pd_pin = 1'b1;
    coast_pin = 1'b1;
    hsync_in = 1'b0;
    vsync_in = 1'b0;
    activity_flags = 6'h00;
    pixel_in = '0;
    tick(20);
    reset_n <= 1'b1;
    rd(REG_HS_WIDTH, rq);
    chk(rq, RST_HS_WIDTH);
    rd(REG_POWER, rq);
    chk(rq, RST_POWER);
    rd(8'h40, rq);
    chk(rq, 8'h00);
    for (int i = 0; i < 6; i++) begin
      activity_flags <= 6'h01 << i;
      pwr_chk(PS_FULL, 1'b1);
    end
    activity_flags <= 6'h00;
    pwr_chk(PS_SEEK, 1'b1);
    wr(REG_AUTO_PD, 8'h80);
    pwr_chk(PS_AUTO_PD, 1'b0);
    wr(REG_POWER, 8'h00);
    pwr_chk(PS_POWER_DOWN, 1'b0);
    activity_flags <= 6'h3F;
    pwr_chk(PS_POWER_DOWN, 1'b0);
    wr(REG_POWER, 8'h01);
    pwr_chk(PS_FULL, 1'b1);
    for (int i = 4; i < 8; i++) begin
      wr(REG_POWER, 8'h01 | (8'h01 << i));
      tick(4);
      chk(hiz, 4'h1 << (i - 4));
    end
    wr(REG_PHASE, 8'h1F);
    chk(phase_step, 5'h1F);
    for (int o = 0; o < 4; o++) begin
      pd_pin <= 1'b0;
      wr(REG_POWER, 8'h09 | 8'(o << 1));
      pd_pin <= 1'b1;
      pwr_chk(PS_POWER_DOWN, 1'b0);
      chk(pin_pd_option, o);
    end
    pd_pin <= 1'b0;
    pwr_chk(PS_FULL, 1'b1);
    wr(REG_HS_WIDTH, 8'h05);
    pulses(3, hi);
    chk(hs_width, 8'h0A);
    chk(hi > 0, 1);
    coast_pin <= 1'b0;
    tick(10);
    pulses(3, hi);
    chk(hi, 0);
    coast_pin <= 1'b1;
    // Coast polarity one: the idle-high pin now counts as coasting
    wr(REG_COAST, 8'h01);
    pulses(2, hi);
    chk(hi, 0);
    // Internal coast, then vsync selected, both driven from vsync
    for (int c = 1; c < 3; c++) begin
      wr(REG_COAST, 8'h01 << c);
      vsync_in <= 1'b1;
      tick(10);
      pulses(2, hi);
      chk(hi, 0);
      vsync_in <= 1'b0;
      tick(10);
      pulses(2, hi);
      chk(hi > 0, 1);
    end
    wr(REG_COAST, RST_COAST);
    // Active-low output: idle level becomes high
    wr(REG_SYNC_OUT, 8'h00);
    tick(4);
    chk(hsync_output, 1'b1);
    wr(REG_SYNC_OUT, RST_SYNC_OUT);
    pq = 24'($random(seed));
    pixel_in <= pq;
    tick(60);
    pq = 24'($random(seed));
    pixel_in <= pq;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pixel_out !== pq && n < 100);
    chk(n >= 46 && n <= 49, 1);
    tick(4);
    chk(last_pix, pq);
    chk(data_valid, 1'b1);
    print_verdict();
  end
endmodule : power_sync_ctrl_tb

bind power_sync_ctrl power_sync_ctrl_asserts i_chk (.clk, .reset_n,
  .scl_in, .coast_pin, .pixel_out, .output_data_clock, .data_valid,
  .hsync_output, .pll_ref, .phase_step, .power_state, .core_power_on);
